// *** hw/ub_pkg.sv ***
package ub_pkg;
    localparam logic [31:0] CLK_HZ = 32'h017d_7840;
    localparam logic [19:0] BAUD_MIN = 20'h0_04b0;
    localparam logic [19:0] BAUD_MAX = 20'h7_a120;
    localparam logic [19:0] OVR_BAUD = 20'h0_2580;
    localparam logic [19:0] CFG_BAUD_RESET = OVR_BAUD;
    localparam logic [15:0] OVR_DIV = 16'(CLK_HZ / 32'(OVR_BAUD));
    localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / 32'(BAUD_MAX));
    localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / 32'(BAUD_MIN));
    localparam logic [6:0] FRAME_BYTES = 7'h40;
    localparam logic [2:0] H2T_FRAMES = 3'h4;
    localparam logic [3:0] T2H_FRAMES = 4'h8;
    localparam logic [5:0] OVR_MAX_CHARS = 6'h32;
    localparam logic [6:0] PREFIX_LEN = 7'h0e;
    localparam int FLUSH_MS = 100;
    localparam int SOF_MS = 1;
    localparam logic [6:0] SOF_PER_FLUSH = 7'(FLUSH_MS / SOF_MS);
    // Command prefix, first character at the highest index
    localparam logic [13:0][7:0] OVR_PREFIX = {
        8'h43, 8'h4d, 8'h44, 8'h3a, 8'h53, 8'h45, 8'h4e,
        8'h44, 8'h5f, 8'h55, 8'h41, 8'h52, 8'h54, 8'h3d};

    typedef enum logic [1:0] {UB_PAR_NONE, UB_PAR_ODD, UB_PAR_EVEN} ub_parity_t;

    typedef struct packed {
        logic [19:0] baud;
        ub_parity_t parity;
        logic two_stop;
    } ub_line_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } ub_byte_t;
endpackage

// *** hw/ub_uart_tx.sv ***
`timescale 1ns/1ns
module ub_uart_tx (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Character request
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic [15:0] div,
    input wire ub_pkg::ub_parity_t parity,
    input wire logic two_stop,
    // Line
    output logic busy,
    output logic line
);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ub_tx_state_t;
    typedef struct packed {
        ub_tx_state_t st;
        logic [15:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic par;
        logic stop2;
        logic busy;
        logic line;
    } ub_tx_st_t;

    ub_tx_st_t s_r, s_nxt;
    logic tick;

    always_comb
    begin
        s_nxt = s_r;
        tick = (s_r.cnt == 16'h0000);
        if (s_r.st != TX_IDLE)
        begin
            s_nxt.cnt = tick ? div - 16'h0001 : s_r.cnt - 16'h0001;
        end
        unique case (s_r.st)
            TX_IDLE:
                if (start)
                begin
                    s_nxt.st = TX_START;
                    s_nxt.cnt = div - 16'h0001;
                    s_nxt.sh = data;
                    s_nxt.par = (parity == ub_pkg::UB_PAR_ODD);
                    s_nxt.stop2 = two_stop;
                    s_nxt.line = 1'b0;
                    s_nxt.busy = 1'b1;
                end
            TX_START, TX_DATA:
                if (tick)
                begin
                    if (s_r.st == TX_DATA && s_r.bitn == 3'h7)
                    begin
                        s_nxt.st = (parity == ub_pkg::UB_PAR_NONE) ? TX_STOP : TX_PAR;
                        s_nxt.line = (parity == ub_pkg::UB_PAR_NONE) ? 1'b1 : s_r.par;
                    end
                    else
                    begin
                        s_nxt.st = TX_DATA;
                        s_nxt.bitn = (s_r.st == TX_START) ? 3'h0 : s_r.bitn + 3'h1;
                        s_nxt.line = s_r.sh[0];
                        s_nxt.par = s_r.par ^ s_r.sh[0];
                        s_nxt.sh = {1'b0, s_r.sh[7:1]};
                    end
                end
            TX_PAR:
                if (tick)
                begin
                    s_nxt.st = TX_STOP;
                    s_nxt.line = 1'b1;
                end
            TX_STOP:
                if (tick)
                begin
                    if (s_r.stop2)
                    begin
                        s_nxt.stop2 = 1'b0;
                    end
                    else
                    begin
                        s_nxt.st = TX_IDLE;
                        s_nxt.busy = 1'b0;
                    end
                end
            default:
                s_nxt.st = TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '{st: TX_IDLE, line: 1'b1, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign line = s_r.line;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_start_bit_low: assert property (start && !s_r.busy |=> !line && busy)
        else $error("start bit not driven low");
    a_idle_high: assert property (!busy |-> line)
        else $error("idle line not high");
endmodule

// *** hw/ub_uart_rx.sv ***
`timescale 1ns/1ns
module ub_uart_rx (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Line and settings
    input wire logic rxd,
    input wire logic enable,
    input wire logic [15:0] div,
    input wire ub_pkg::ub_parity_t parity,
    // Received character
    output logic valid,
    output logic [7:0] data
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ub_rx_state_t;
    typedef struct packed {
        ub_rx_state_t st;
        logic [15:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic par;
        logic perr;
        logic valid;
    } ub_rx_st_t;

    ub_rx_st_t s_r, s_nxt;
    logic tick;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.valid = 1'b0;
        tick = (s_r.cnt == 16'h0000);
        if (s_r.st != RX_IDLE)
        begin
            s_nxt.cnt = tick ? div - 16'h0001 : s_r.cnt - 16'h0001;
        end
        unique case (s_r.st)
            RX_IDLE:
                if (enable && !rxd)
                begin
                    s_nxt.st = RX_START;
                    s_nxt.cnt = {1'b0, div[15:1]};
                end
            RX_START:
                if (tick)
                begin
                    s_nxt.st = rxd ? RX_IDLE : RX_DATA;
                    s_nxt.bitn = 3'h0;
                    s_nxt.perr = 1'b0;
                    s_nxt.par = (parity == ub_pkg::UB_PAR_ODD);
                end
            RX_DATA:
                if (tick)
                begin
                    s_nxt.sh = {rxd, s_r.sh[7:1]};
                    s_nxt.par = s_r.par ^ rxd;
                    s_nxt.bitn = s_r.bitn + 3'h1;
                    if (s_r.bitn == 3'h7)
                    begin
                        s_nxt.st = (parity == ub_pkg::UB_PAR_NONE) ? RX_STOP : RX_PAR;
                    end
                end
            RX_PAR:
                if (tick)
                begin
                    s_nxt.perr = s_r.par ^ rxd;
                    s_nxt.st = RX_STOP;
                end
            RX_STOP:
                if (tick)
                begin
                    s_nxt.st = RX_IDLE;
                    s_nxt.valid = rxd && !s_r.perr && enable;
                end
            default:
                s_nxt.st = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '{st: RX_IDLE, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign valid = s_r.valid;
    assign data = s_r.sh;
endmodule

// *** hw/ub_bridge.sv ***
`timescale 1ns/1ns
module ub_bridge (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Line settings and session
    input wire logic cfg_wr,
    input wire ub_pkg::ub_line_cfg_t cfg_wdata,
    output ub_pkg::ub_line_cfg_t cfg_rdata,
    input wire logic dtr,
    input wire logic sof,
    output logic session_active,
    output logic level_shift_en,
    // Host-to-target frames
    input wire logic h2t_valid,
    input wire ub_pkg::ub_byte_t h2t_byte,
    output logic h2t_ready,
    output logic [2:0] h2t_frames,
    // Override message
    input wire logic ovr_valid,
    input wire ub_pkg::ub_byte_t ovr_byte,
    // Target-to-host frames
    output logic t2h_valid,
    output ub_pkg::ub_byte_t t2h_byte,
    input wire logic t2h_ready,
    output logic overrun,
    // Target pins
    input wire logic bridge_serial_in_pin,
    output logic bridge_serial_out_pin
);
    typedef struct packed {
        ub_pkg::ub_line_cfg_t cfg;
        logic cfg_seen;
        logic active;
        logic ls_en;
        logic [2:0] sync;
        logic rxd;
        logic [ub_pkg::H2T_FRAMES-1:0][ub_pkg::FRAME_BYTES-1:0][7:0] h_mem;
        logic [ub_pkg::H2T_FRAMES-1:0][6:0] h_len;
        logic [1:0] h_wr;
        logic [1:0] h_rd;
        logic [6:0] h_wp;
        logic [6:0] h_rp;
        logic [2:0] h_cnt;
        logic h_rdy;
        logic [ub_pkg::OVR_MAX_CHARS-1:0][7:0] o_mem;
        logic [5:0] o_len;
        logic [5:0] o_rp;
        logic [6:0] o_in;
        logic o_match;
        logic o_pend;
        logic tx_start;
        logic [7:0] tx_data;
        logic [15:0] tx_div;
        logic [ub_pkg::T2H_FRAMES-1:0][ub_pkg::FRAME_BYTES-1:0][7:0] t_mem;
        logic [ub_pkg::T2H_FRAMES-1:0][6:0] t_len;
        logic [2:0] t_fill;
        logic [2:0] t_rd;
        logic [6:0] t_fp;
        logic [6:0] t_rp;
        logic [3:0] t_q;
        logic [6:0] sof_cnt;
        logic t_valid;
        ub_pkg::ub_byte_t t_out;
        logic overrun;
    } ub_top_st_t;

    ub_top_st_t s_r, s_nxt;
    logic tx_busy;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [19:0] baud_lim;
    logic [15:0] div_cfg;
    logic h_push, h_pop, t_push, t_pop, flush;

    always_comb
    begin
        s_nxt = s_r;
        h_push = 1'b0;
        h_pop = 1'b0;
        t_push = 1'b0;
        t_pop = 1'b0;
        s_nxt.tx_start = 1'b0;
        s_nxt.overrun = 1'b0;

        // Rate clamp and divisor, follows the stored rate live
        if (s_r.cfg.baud < ub_pkg::BAUD_MIN)
        begin
            baud_lim = ub_pkg::BAUD_MIN;
        end
        else if (s_r.cfg.baud > ub_pkg::BAUD_MAX)
        begin
            baud_lim = ub_pkg::BAUD_MAX;
        end
        else
        begin
            baud_lim = s_r.cfg.baud;
        end
        div_cfg = 16'(ub_pkg::CLK_HZ / 32'(baud_lim));

        // Settings and session
        if (cfg_wr)
        begin
            s_nxt.cfg = cfg_wdata;
            s_nxt.cfg_seen = 1'b1;
        end
        s_nxt.active = dtr;
        if (dtr)
        begin
            s_nxt.ls_en = 1'b1;
            s_nxt.cfg_seen = 1'b1;
        end

        // Target pin synchroniser
        s_nxt.sync = {s_r.sync[1:0], bridge_serial_in_pin};
        if (s_r.sync[2] == s_r.sync[1])
        begin
            s_nxt.rxd = s_r.sync[2];
        end

        // Host frames fill a slot; a frame ends on last or 64 bytes
        if (h2t_valid && s_r.h_rdy)
        begin
            s_nxt.h_mem[s_r.h_wr][s_r.h_wp[5:0]] = h2t_byte.data;
            if (h2t_byte.last || s_r.h_wp == ub_pkg::FRAME_BYTES - 7'h01)
            begin
                s_nxt.h_len[s_r.h_wr] = s_r.h_wp + 7'h01;
                s_nxt.h_wr = s_r.h_wr + 2'h1;
                s_nxt.h_wp = 7'h00;
                h_push = 1'b1;
            end
            else
            begin
                s_nxt.h_wp = s_r.h_wp + 7'h01;
            end
        end
        if (!dtr)
        begin
            s_nxt.h_wp = 7'h00;
        end

        // Serialiser feed: override message first, then queued frames
        if (!tx_busy && !s_r.tx_start)
        begin
            if (s_r.o_pend)
            begin
                s_nxt.tx_start = 1'b1;
                s_nxt.tx_data = s_r.o_mem[s_r.o_rp];
                s_nxt.tx_div = s_r.cfg_seen ? div_cfg : ub_pkg::OVR_DIV;
                if (s_r.o_rp == s_r.o_len - 6'h01)
                begin
                    s_nxt.o_pend = 1'b0;
                    s_nxt.o_rp = 6'h00;
                    s_nxt.o_len = 6'h00;
                end
                else
                begin
                    s_nxt.o_rp = s_r.o_rp + 6'h01;
                end
            end
            else if (s_r.h_cnt != 3'h0)
            begin
                s_nxt.tx_start = 1'b1;
                s_nxt.tx_data = s_r.h_mem[s_r.h_rd][s_r.h_rp[5:0]];
                s_nxt.tx_div = div_cfg;
                if (s_r.h_rp == s_r.h_len[s_r.h_rd] - 7'h01)
                begin
                    s_nxt.h_rd = s_r.h_rd + 2'h1;
                    s_nxt.h_rp = 7'h00;
                    h_pop = 1'b1;
                end
                else
                begin
                    s_nxt.h_rp = s_r.h_rp + 7'h01;
                end
            end
        end
        s_nxt.h_cnt = s_r.h_cnt + 3'(h_push) - 3'(h_pop);
        s_nxt.h_rdy = dtr && (s_nxt.h_cnt < ub_pkg::H2T_FRAMES);

        // Override text: check prefix, keep up to the cap, drop the rest
        if (ovr_valid && !s_r.o_pend)
        begin
            if (s_r.o_in < ub_pkg::PREFIX_LEN)
            begin
                if (ovr_byte.data != ub_pkg::OVR_PREFIX[4'(ub_pkg::PREFIX_LEN - 7'h01 - s_r.o_in)])
                begin
                    s_nxt.o_match = 1'b0;
                end
            end
            else if (s_r.o_match && s_r.o_len < ub_pkg::OVR_MAX_CHARS)
            begin
                s_nxt.o_mem[s_r.o_len] = ovr_byte.data;
                s_nxt.o_len = s_r.o_len + 6'h01;
            end
            if (s_r.o_in != 7'h7f)
            begin
                s_nxt.o_in = s_r.o_in + 7'h01;
            end
            if (ovr_byte.last)
            begin
                s_nxt.o_pend = s_nxt.o_match && (s_nxt.o_len != 6'h00);
                if (!s_nxt.o_pend)
                begin
                    s_nxt.o_len = 6'h00;
                end
                s_nxt.o_in = 7'h00;
                s_nxt.o_match = 1'b1;
            end
        end

        // Target bytes packed into frames
        if (rx_valid)
        begin
            s_nxt.t_mem[s_r.t_fill][s_r.t_fp[5:0]] = rx_data;
            s_nxt.t_fp = s_r.t_fp + 7'h01;
        end
        flush = sof && (s_r.sof_cnt == ub_pkg::SOF_PER_FLUSH - 7'h01);
        if (sof)
        begin
            s_nxt.sof_cnt = flush ? 7'h00 : s_r.sof_cnt + 7'h01;
        end
        if (s_nxt.t_fp == ub_pkg::FRAME_BYTES || (flush && s_nxt.t_fp != 7'h00))
        begin
            if (s_r.t_q < ub_pkg::T2H_FRAMES - 4'h1)
            begin
                s_nxt.t_len[s_r.t_fill] = s_nxt.t_fp;
                s_nxt.t_fill = s_r.t_fill + 3'h1;
                s_nxt.t_fp = 7'h00;
                t_push = 1'b1;
            end
            else if (s_nxt.t_fp == ub_pkg::FRAME_BYTES)
            begin
                s_nxt.t_fp = 7'h00;
                s_nxt.overrun = 1'b1;
            end
        end

        // Output stage toward the host
        if (!s_r.t_valid || t2h_ready)
        begin
            s_nxt.t_valid = 1'b0;
            if (s_r.t_q != 4'h0)
            begin
                s_nxt.t_valid = 1'b1;
                s_nxt.t_out.data = s_r.t_mem[s_r.t_rd][s_r.t_rp[5:0]];
                s_nxt.t_out.last = (s_r.t_rp == s_r.t_len[s_r.t_rd] - 7'h01);
                if (s_nxt.t_out.last)
                begin
                    s_nxt.t_rd = s_r.t_rd + 3'h1;
                    s_nxt.t_rp = 7'h00;
                    t_pop = 1'b1;
                end
                else
                begin
                    s_nxt.t_rp = s_r.t_rp + 7'h01;
                end
            end
        end
        s_nxt.t_q = s_r.t_q + 4'(t_push) - 4'(t_pop);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '{cfg: '{baud: ub_pkg::CFG_BAUD_RESET, parity: ub_pkg::UB_PAR_NONE,
                two_stop: 1'b0}, sync: 3'h7, rxd: 1'b1, o_match: 1'b1,
                tx_div: ub_pkg::OVR_DIV, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ub_uart_tx u_tx (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(s_r.tx_start),
        .data(s_r.tx_data),
        .div(s_r.tx_div),
        .parity(s_r.cfg.parity),
        .two_stop(s_r.cfg.two_stop),
        .busy(tx_busy),
        .line(bridge_serial_out_pin)
    );

    ub_uart_rx u_rx (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rxd(s_r.rxd),
        .enable(s_r.active),
        .div(div_cfg),
        .parity(s_r.cfg.parity),
        .valid(rx_valid),
        .data(rx_data)
    );

    assign cfg_rdata = s_r.cfg;
    assign session_active = s_r.active;
    assign level_shift_en = s_r.ls_en;
    assign h2t_ready = s_r.h_rdy;
    assign h2t_frames = s_r.h_cnt;
    assign t2h_valid = s_r.t_valid;
    assign t2h_byte = s_r.t_out;
    assign overrun = s_r.overrun;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_idle_refuses: assert property (!session_active |-> !h2t_ready)
        else $error("host data accepted outside session");
    a_dtr_opens: assert property ($rose(dtr) |=> session_active && level_shift_en)
        else $error("session not opened on DTR");
    a_shifter_holds: assert property (level_shift_en |=> level_shift_en)
        else $error("level shifters dropped");
    a_rx_gated: assert property (!dtr ##1 !dtr ##1 !dtr |-> !rx_valid)
        else $error("target byte received without session");
    a_drain_after_dtr: assert property (!dtr && h2t_frames != 3'h0 && !tx_busy
        && !s_r.tx_start && !s_r.o_pend |=> s_r.tx_start)
        else $error("queued frame not drained");
    a_frames_max: assert property (h2t_frames <= ub_pkg::H2T_FRAMES)
        else $error("too many host frames");
    a_full_holds: assert property (h2t_frames == ub_pkg::H2T_FRAMES |-> !h2t_ready)
        else $error("host not held off");
    a_ovr_cap: assert property (s_r.o_len <= ub_pkg::OVR_MAX_CHARS)
        else $error("override message too long");
    a_ovr_rate: assert property (s_r.o_pend && !s_r.cfg_seen && !tx_busy && !s_r.tx_start
        |=> s_r.tx_div == ub_pkg::OVR_DIV)
        else $error("override default rate wrong");
    a_rx_slots: assert property (s_r.t_q < ub_pkg::T2H_FRAMES)
        else $error("receive slots exceeded");
    a_overrun_full: assert property (overrun |-> $past(s_r.t_q) == 4'h7 && s_r.t_fp == 7'h00)
        else $error("overrun without full queue");
    a_div_clamp: assert property (div_cfg >= ub_pkg::DIV_MIN && div_cfg <= ub_pkg::DIV_MAX)
        else $error("baud divisor out of range");
    c_host_frame: cover property (h_push && h2t_frames == 3'h3);
    c_flush: cover property (flush && t_push);
    c_overrun: cover property (overrun);
    c_ovr_send: cover property (s_r.o_pend ##1 s_r.tx_start);
endmodule

// *** testbench/ub_target_model.sv ***
`timescale 1ns/1ns
module ub_target_model (
    // Clock
    ref_clk,
    // Serial lines
    serial_from_bridge,
    serial_to_bridge
);
    input wire logic ref_clk;
    input wire logic serial_from_bridge;
    output logic serial_to_bridge;

    // Line idles high between characters
    initial serial_to_bridge = 1'b1;

    // Start bit, eight data bits LSB first, one stop bit
    task automatic send_char(input logic [7:0] d, input int bit_cyc);
        @(posedge ref_clk);
        #1 serial_to_bridge = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            repeat (bit_cyc) @(posedge ref_clk);
            #1 serial_to_bridge = (i < 8) ? d[i] : 1'b1;
        end
    endtask

    // Samples mid-bit; the bit after the eight data bits (parity if enabled, else stop) lands in the top position
    task automatic recv_char(output logic [8:0] d, input int bit_cyc);
        @(negedge serial_from_bridge);
        repeat (bit_cyc + bit_cyc / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++)
        begin
            d[i] = serial_from_bridge;
            if (i < 8)
                repeat (bit_cyc) @(posedge ref_clk);
        end
    endtask
endmodule

// *** testbench/ub_bridge_test.sv ***
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module ub_bridge_test;
    localparam int BIT_CYC = 50;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfg_wr = 1'b0;
    ub_pkg::ub_line_cfg_t cfg_wdata = '0;
    ub_pkg::ub_line_cfg_t cfg_rdata;
    logic dtr = 1'b0;
    logic sof = 1'b0;
    logic session_active, level_shift_en, h2t_ready, t2h_valid, overrun;
    logic h2t_valid = 1'b0;
    logic ovr_valid = 1'b0;
    logic t2h_ready = 1'b1;
    ub_pkg::ub_byte_t h2t_byte = '0;
    ub_pkg::ub_byte_t ovr_byte = '0;
    ub_pkg::ub_byte_t t2h_byte;
    logic [2:0] h2t_frames;
    logic bridge_serial_in_pin, bridge_serial_out_pin;
    logic [8:0] rx_char;
    int fail_count = 0;
    int tests_run = 0;
    int t2h_seen = 0;
    int seen_before = 0;
    int ovr_seen = 0;
    int bit_len = 0;
    ub_pkg::ub_byte_t t2h_got = '0;

    always #20 ref_clk = ~ref_clk;

    // Counts bytes taken by the host and overrun pulses
    always @(posedge ref_clk)
    begin
        if (t2h_valid === 1'b1 && t2h_ready === 1'b1)
        begin
            t2h_seen++;
            t2h_got = t2h_byte;
        end
        if (overrun === 1'b1)
            ovr_seen++;
    end

    ub_bridge dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .dtr(dtr), .sof(sof), .session_active(session_active),
        .level_shift_en(level_shift_en), .h2t_valid(h2t_valid), .h2t_byte(h2t_byte),
        .h2t_ready(h2t_ready), .h2t_frames(h2t_frames), .ovr_valid(ovr_valid),
        .ovr_byte(ovr_byte), .t2h_valid(t2h_valid), .t2h_byte(t2h_byte),
        .t2h_ready(t2h_ready), .overrun(overrun), .bridge_serial_in_pin(bridge_serial_in_pin),
        .bridge_serial_out_pin(bridge_serial_out_pin));

    ub_target_model target (.ref_clk(ref_clk), .serial_from_bridge(bridge_serial_out_pin),
        .serial_to_bridge(bridge_serial_in_pin));

    task automatic report_and_stop;
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic cfg_write(input logic [19:0] baud, input ub_pkg::ub_parity_t par,
        input logic two);
        cfg_wdata = '{baud: baud, parity: par, two_stop: two};
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
    endtask

    task automatic sof_burst(input int n);
        repeat (n)
        begin
            sof = 1'b1;
            step(1);
            sof = 1'b0;
            step(4);
        end
    endtask

    // One-byte host frame, held until taken
    task automatic h2t_put(input logic [7:0] d);
        h2t_byte = '{data: d, last: 1'b1};
        h2t_valid = 1'b1;
        for (int i = 0; i < 2000 && h2t_ready !== 1'b1; i++)
            step(1);
        `CHK("h2t_ready", 1'b1, h2t_ready)
        step(1);
        h2t_valid = 1'b0;
        step(1);
    endtask

    // Override text frame: command prefix then n payload characters
    task automatic ovr_msg(input int n);
        ovr_valid = 1'b1;
        for (int i = 0; i < 14 + n; i++)
        begin
            ovr_byte = '{data: (i < 14) ? ub_pkg::OVR_PREFIX[13 - i] : 8'h31 + 8'(i - 14),
                last: (i == 13 + n)};
            step(1);
        end
        ovr_valid = 1'b0;
    endtask

    initial
    begin
        #(40 * 95000);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        step(6);
        rst_b = 1'b1;
        `CHK("cfg_reset", {ub_pkg::OVR_BAUD, ub_pkg::UB_PAR_NONE, 1'b0}, cfg_rdata)
        `CHK("shift_idle", 1'b0, level_shift_en)
        cfg_write(20'h9_27c0, ub_pkg::UB_PAR_NONE, 1'b0);
        step(1);
        `CHK("cfg_readback", 20'h9_27c0, cfg_rdata.baud)
        `CHK("ready_pre", 1'b0, h2t_ready)
        dtr = 1'b1;
        step(2);
        `CHK("session", 1'b1, session_active)
        `CHK("shift_on", 1'b1, level_shift_en)
        `CHK("ready_on", 1'b1, h2t_ready)
        fork
            h2t_put(8'h5a);
            target.recv_char(rx_char, BIT_CYC);
        join
        `CHK("serial_out", {1'b1, 8'h5a}, rx_char)
        seen_before = t2h_seen;
        target.send_char(8'ha5, BIT_CYC);
        sof_burst(100);
        `CHK("t2h_count", seen_before + 1, t2h_seen)
        `CHK("t2h_byte", {8'ha5, 1'b1}, t2h_got)
        fork
            begin
                for (int i = 0; i < 5; i++)
                    h2t_put(8'h10 + 8'(i));
                step(1);
                `CHK("frames_max", 3'h4, h2t_frames)
                `CHK("throttle", 1'b0, h2t_ready)
                dtr = 1'b0;
                step(2);
                `CHK("shift_kept", 1'b1, level_shift_en)
                `CHK("refuse_new", 1'b0, h2t_ready)
            end
            for (int i = 0; i < 5; i++)
            begin
                target.recv_char(rx_char, BIT_CYC);
                `CHK("drain", {1'b1, 8'h10 + 8'(i)}, rx_char)
            end
        join
        seen_before = t2h_seen;
        target.send_char(8'h3c, BIT_CYC);
        sof_burst(100);
        step(20);
        `CHK("rx_off", seen_before, t2h_seen)
        fork
            ovr_msg(52);
            for (int j = 0; j < 50; j++)
            begin
                target.recv_char(rx_char, BIT_CYC);
                `CHK("ovr_char", {1'b1, 8'h31 + 8'(j)}, rx_char)
            end
        join
        step(50);
        `CHK("ovr_cap", 1'b1, bridge_serial_out_pin)
        cfg_write(20'h9_27c0, ub_pkg::UB_PAR_ODD, 1'b1);
        dtr = 1'b1;
        fork
            begin
                h2t_put(8'h07);
                h2t_put(8'h03);
            end
            begin
                target.recv_char(rx_char, BIT_CYC);
                `CHK("par_odd0", {1'b0, 8'h07}, rx_char)
                step(2 * BIT_CYC);
                `CHK("stop_two", 1'b1, bridge_serial_out_pin)
                target.recv_char(rx_char, BIT_CYC);
                `CHK("par_odd1", {1'b1, 8'h03}, rx_char)
            end
        join
        cfg_write(20'h9_27c0, ub_pkg::UB_PAR_NONE, 1'b0);
        t2h_ready = 1'b0;
        seen_before = t2h_seen;
        for (int i = 0; i < 8; i++)
        begin
            target.send_char(8'(i), BIT_CYC);
            sof_burst(100);
        end
        for (int i = 0; i < 64; i++)
            target.send_char(8'(i), BIT_CYC);
        `CHK("overrun", 1, ovr_seen)
        t2h_ready = 1'b1;
        step(20);
        `CHK("t2h_slots", seen_before + 8, t2h_seen)
        `CHK("t2h_last", {8'h07, 1'b1}, t2h_got)
        dtr = 1'b0;
        rst_b = 1'b0;
        step(2);
        rst_b = 1'b1;
        `CHK("cfg_reset2", {ub_pkg::OVR_BAUD, ub_pkg::UB_PAR_NONE, 1'b0}, cfg_rdata)
        `CHK("shift_reset", 1'b0, level_shift_en)
        fork
            ovr_msg(1);
            begin
                @(negedge bridge_serial_out_pin);
                for (bit_len = 0; bridge_serial_out_pin === 1'b0 && bit_len < 5000; bit_len++)
                    step(1);
            end
        join
        `CHK("ovr_rate", int'(ub_pkg::OVR_DIV), bit_len)
        report_and_stop();
    end
endmodule
